// *** rtl/adc_conversion_sequencer.sv ***
// How it works
// - Conversion clock is system clock divided by 2^select, 000 none, 111 by 128.
// - Analog circuitry is powered only while the power-on bit is high.
// - Conversion is 4 ticks of sampling then 12 of conversion, 16 total.
// - Conversion runs on its own; the processor keeps executing meanwhile.
// - An internal input source disconnects the external channel regardless of channel field.
// - Source codes 000 and 100 route the selected external channel, others internal.
// - Supply or bandgap reference switches off the external reference pin path.
// - A format bit selects how the result splits across high and low bytes.
// - Start bit low, high, low again launches a conversion.
// - Busy stays high during conversion and falls at completion with result valid.
// - Busy is set automatically once a conversion is accepted.
// - Completion sets the interrupt request flag and raises an interrupt when enabled.
// - Interrupt is serviced only when enabled and the return stack is not full.
`timescale 1ns/100ps
module adc_conversion_sequencer
    import adc_seq_pkg::*;
(
    input wire logic sys_clk_in, // System clock, 25 MHz
    input wire logic resetn_in, // Async reset, active low
    input wire logic [DIV_SEL_W-1:0] conv_clock_div_sel_in, // Prescaler select
    input wire logic converter_power_on_in, // Converter enable bit
    input wire logic [2:0] input_source_sel_in, // Input source field
    input wire logic [3:0] external_channel_sel_in, // External channel field
    input wire logic [3:0] reference_source_sel_in, // Reference source field
    input wire logic result_format_sel_in, // Result format bit
    input wire logic start_in, // Start bit as written by software
    input wire logic global_int_enable_in, // Global interrupt enable
    input wire logic conv_int_enable_in, // Converter interrupt enable
    input wire logic stack_full_in, // Return-address stack full
    input wire logic int_request_clear_in, // Software clear of request flag
    output logic analog_power_out, // Analog core power gate
    output logic sample_phase_out, // Sampling switch closed
    output logic convert_phase_out, // Successive approximation running
    output logic conv_tick_out, // Conversion clock tick to core
    output logic conv_busy_flag_out, // Conversion in progress
    output logic conv_done_out, // One-cycle completion pulse, result valid
    output logic conv_int_request_out, // Sticky interrupt request flag
    output logic conv_int_service_out, // Interrupt may be taken
    output logic external_channel_connect_out, // External channel switch on
    output logic [3:0] channel_mux_sel_out, // External channel mux select
    output logic [2:0] internal_signal_sel_out, // Internal signal select
    output logic external_reference_pin_on_out, // Reference path from pin on
    output logic [3:0] reference_mux_sel_out, // Reference mux select
    output logic result_format_out // Result layout select to result bytes
);
    typedef struct packed {
        seq_state_t state;
        logic [PHASE_W-1:0] phase_count;
        logic start_seen_high;
        logic power;
        logic tick;
        logic busy;
        logic done;
        logic int_request;
        logic int_service;
        logic ext_connect;
        logic [3:0] channel;
        logic [2:0] internal_sel;
        logic ext_ref_on;
        logic [3:0] ref_sel;
        logic format;
        logic sample;
        logic convert;
    } seq_reg_t;

    seq_reg_t r;
    seq_reg_t next_r;
    logic tick;
    logic start_accept;
    logic ref_internal;
    logic src_external;

    conv_prescaler u_prescaler (
        .sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in),
        .div_sel_in(conv_clock_div_sel_in),
        .tick_out(tick)
    );

    always_comb begin
        src_external = (input_source_sel_in == SRC_EXT_A) ||
                       (input_source_sel_in == SRC_EXT_B);
        ref_internal = (reference_source_sel_in == REF_VDD_LOW) ||
                       (reference_source_sel_in >= REF_VDD_HIGH_FIRST) ||
                       ((reference_source_sel_in >= REF_BG_FIRST) &&
                        (reference_source_sel_in <= REF_BG_LAST));
        // Full low-high-low pulse, accepted on the falling edge
        start_accept = r.start_seen_high && !start_in && converter_power_on_in &&
                       (r.state == SEQ_IDLE);
        next_r = r;
        next_r.done = 1'b0;
        next_r.tick = tick;
        next_r.power = converter_power_on_in;
        if (start_in) begin
            next_r.start_seen_high = 1'b1;
        end else begin
            next_r.start_seen_high = 1'b0;
        end
        case (r.state)
            SEQ_IDLE: begin
                if (start_accept) begin
                    next_r.state = SEQ_SAMPLE;
                    next_r.phase_count = PHASE_COUNT_RESET;
                    next_r.busy = 1'b1;
                end
            end
            SEQ_SAMPLE: begin
                if (tick) begin
                    if (r.phase_count == SAMPLE_TICKS - 4'h1) begin
                        next_r.state = SEQ_CONVERT;
                        next_r.phase_count = PHASE_COUNT_RESET;
                    end else begin
                        next_r.phase_count = r.phase_count + 4'h1;
                    end
                end
            end
            SEQ_CONVERT: begin
                if (tick) begin
                    if (r.phase_count == CONVERT_TICKS - 4'h1) begin
                        next_r.state = SEQ_IDLE;
                        next_r.phase_count = PHASE_COUNT_RESET;
                        next_r.busy = 1'b0;
                        next_r.done = 1'b1;
                    end else begin
                        next_r.phase_count = r.phase_count + 4'h1;
                    end
                end
            end
            default: begin
                next_r.state = SEQ_IDLE;
                next_r.phase_count = PHASE_COUNT_RESET;
                next_r.busy = 1'b0;
            end
        endcase
        // Abort takes priority over completion
        if (!converter_power_on_in) begin
            next_r.state = SEQ_IDLE;
            next_r.phase_count = PHASE_COUNT_RESET;
            next_r.busy = 1'b0;
            next_r.done = 1'b0;
        end
        // Set wins over a clear in the same cycle
        if (next_r.done) begin
            next_r.int_request = 1'b1;
        end else if (int_request_clear_in) begin
            next_r.int_request = 1'b0;
        end
        next_r.int_service = r.int_request && global_int_enable_in &&
                             conv_int_enable_in && !stack_full_in;
        next_r.ext_connect = src_external && converter_power_on_in;
        next_r.channel = external_channel_sel_in;
        next_r.internal_sel = input_source_sel_in;
        next_r.ext_ref_on = !ref_internal && converter_power_on_in;
        next_r.ref_sel = reference_source_sel_in;
        next_r.format = result_format_sel_in;
        // Phase outputs decoded ahead so they leave straight from flip-flops
        next_r.sample = (next_r.state == SEQ_SAMPLE);
        next_r.convert = (next_r.state == SEQ_CONVERT);
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            r <= '{state: SEQ_IDLE, phase_count: PHASE_COUNT_RESET, channel: CHANNEL_RESET,
                   internal_sel: SRCSEL_RESET, ref_sel: REFSEL_RESET, default: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    assign analog_power_out = r.power;
    assign sample_phase_out = r.sample;
    assign convert_phase_out = r.convert;
    assign conv_tick_out = r.tick;
    assign conv_busy_flag_out = r.busy;
    assign conv_done_out = r.done;
    assign conv_int_request_out = r.int_request;
    assign conv_int_service_out = r.int_service;
    assign external_channel_connect_out = r.ext_connect;
    assign channel_mux_sel_out = r.channel;
    assign internal_signal_sel_out = r.internal_sel;
    assign external_reference_pin_on_out = r.ext_ref_on;
    assign reference_mux_sel_out = r.ref_sel;
    assign result_format_out = r.format;

    // Helper counters of ticks seen in each phase
    logic [PHASE_W:0] chk_sample_ticks;
    logic [PHASE_W:0] chk_convert_ticks;
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            chk_sample_ticks <= 5'h00;
            chk_convert_ticks <= 5'h00;
        end else begin
            chk_sample_ticks <= !sample_phase_out ? 5'h00 :
                                chk_sample_ticks + {4'h0, tick};
            chk_convert_ticks <= !convert_phase_out ? 5'h00 :
                                 chk_convert_ticks + {4'h0, tick};
        end
    end

    a_start_sets_busy: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        start_accept |=> conv_busy_flag_out && sample_phase_out)
        else $error("accepted start did not set busy");
    a_sample_four_ticks: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        $rose(convert_phase_out) |-> chk_sample_ticks == 5'h04)
        else $error("sampling phase length wrong");
    a_convert_twelve_ticks: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        conv_done_out |-> $past(chk_convert_ticks) == 5'h0b && $past(tick))
        else $error("conversion phase length wrong");
    a_done_sets_flag: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        conv_done_out |-> conv_int_request_out && !conv_busy_flag_out && $past(conv_busy_flag_out))
        else $error("completion did not set request or clear busy");
    a_abort_no_int: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        !converter_power_on_in |=> !conv_busy_flag_out && !conv_done_out && !analog_power_out)
        else $error("power off did not abort quietly");
    a_request_held: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        conv_int_request_out && !int_request_clear_in |=> conv_int_request_out)
        else $error("request flag lost without clear");
    a_service_gate: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        conv_int_service_out |-> !$past(stack_full_in) && $past(conv_int_enable_in) &&
            $past(global_int_enable_in) && $past(conv_int_request_out))
        else $error("interrupt serviced while not allowed");
    a_ext_channel_off: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        (input_source_sel_in != SRC_EXT_A && input_source_sel_in != SRC_EXT_B)
            |=> !external_channel_connect_out)
        else $error("external channel connected with internal source");
    a_ext_ref_off: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        (reference_source_sel_in == REF_VDD_LOW || reference_source_sel_in >= REF_BG_FIRST)
            |=> !external_reference_pin_on_out)
        else $error("reference pin path on with internal reference");
endmodule : adc_conversion_sequencer

// *** shared/adc_seq_pkg.sv ***
package adc_seq_pkg;
    localparam int DIV_SEL_W = 3;
    localparam int PRESCALE_W = 7;
    localparam int PHASE_W = 4;
    // Conversion clock ticks per phase
    localparam logic [PHASE_W-1:0] SAMPLE_TICKS = 4'h4;
    localparam logic [PHASE_W-1:0] CONVERT_TICKS = 4'hc;
    // Input source codes that route the external channel
    localparam logic [2:0] SRC_EXT_A = 3'h0;
    localparam logic [2:0] SRC_EXT_B = 3'h4;
    // Reference source code ranges
    localparam logic [3:0] REF_VDD_LOW = 4'h0;
    localparam logic [3:0] REF_VDD_HIGH_FIRST = 4'hd;
    localparam logic [3:0] REF_BG_FIRST = 4'ha;
    localparam logic [3:0] REF_BG_LAST = 4'hc;
    // Values after reset
    localparam logic [PRESCALE_W-1:0] PRESCALE_RESET = 7'h00;
    localparam logic [PHASE_W-1:0] PHASE_COUNT_RESET = 4'h0;
    localparam logic [3:0] CHANNEL_RESET = 4'h0;
    localparam logic [3:0] REFSEL_RESET = 4'h0;
    localparam logic [2:0] SRCSEL_RESET = 3'h0;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_SAMPLE,
        SEQ_CONVERT
    } seq_state_t;
endpackage : adc_seq_pkg

// *** rtl/conv_prescaler.sv ***
`timescale 1ns/100ps
module conv_prescaler
    import adc_seq_pkg::*;
(
    input wire logic sys_clk_in, // System clock
    input wire logic resetn_in, // Async reset, active low
    input wire logic [DIV_SEL_W-1:0] div_sel_in, // Division 2^div_sel
    output logic tick_out // One-cycle conversion clock tick
);
    typedef struct packed {
        logic [PRESCALE_W-1:0] count;
        logic tick;
    } pre_state_t;

    pre_state_t r;
    pre_state_t next_r;
    logic [PRESCALE_W-1:0] mask;

    always_comb begin
        mask = PRESCALE_W'((8'h01 << div_sel_in) - 8'h01);
        next_r = r;
        next_r.count = r.count + 7'h01;
        next_r.tick = ((r.count & mask) == mask);
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            r <= '{count: PRESCALE_RESET, tick: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    assign tick_out = r.tick;
endmodule : conv_prescaler

// *** sim/analog_core_model.sv ***
`timescale 1ns/100ps
module analog_core_model (
    input wire logic sys_clk_in, // System clock
    input wire logic resetn_in, // Async reset, active low
    input wire logic analog_power_in, // Core power gate
    input wire logic sample_phase_in, // Sampling switch closed
    input wire logic convert_phase_in, // Approximation running
    input wire logic conv_tick_in, // Conversion clock tick
    input wire logic busy_in, // Conversion in progress
    output logic [7:0] sample_cycles_out, // Cycles spent sampling
    output logic [7:0] convert_cycles_out, // Cycles spent converting
    output logic [7:0] busy_ticks_out, // Ticks seen while busy
    output logic unpowered_out // Phase seen with power off
);
    logic busy_seen;
    // Counts restart at each rise of busy so they hold one conversion
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            busy_seen <= 1'b0;
            sample_cycles_out <= 8'h00;
            convert_cycles_out <= 8'h00;
            busy_ticks_out <= 8'h00;
            unpowered_out <= 1'b0;
        end else begin
            busy_seen <= busy_in;
            if (busy_in && !busy_seen) begin
                sample_cycles_out <= {7'h00, sample_phase_in};
                convert_cycles_out <= {7'h00, convert_phase_in};
                // Tick output lags the sequencer by one cycle
                busy_ticks_out <= 8'h00;
            end else begin
                sample_cycles_out <= sample_cycles_out + {7'h00, sample_phase_in};
                convert_cycles_out <= convert_cycles_out + {7'h00, convert_phase_in};
                busy_ticks_out <= busy_ticks_out + {7'h00, conv_tick_in & busy_seen};
            end
            if ((sample_phase_in || convert_phase_in) && !analog_power_in) begin
                unpowered_out <= 1'b1;
            end
        end
    end
endmodule : analog_core_model

// *** sim/tb.sv ***
`timescale 1ns/100ps
module tb;
    import adc_seq_pkg::*;
    logic sys_clk_in = 1'b0, resetn_in = 1'b0, power = 1'b0, fmt = 1'b0, start = 1'b0;
    logic gie = 1'b0, cie = 1'b0, full = 1'b0, clr = 1'b0;
    logic [2:0] div = 3'h0, src = 3'h0;
    logic [3:0] chan = 4'hb, refs = 4'h1;
    logic pwr_o, smp_o, cnv_o, tick_o, busy_o, done_o, req_o, svc_o, ext_o, pin_o, fmt_o, unpw;
    logic [3:0] chan_o, ref_o;
    logic [2:0] int_o;
    logic [7:0] n_smp, n_cnv, n_tck;
    int n_mismatch = 0, checks = 0;
    always #20 sys_clk_in = ~sys_clk_in;
    adc_conversion_sequencer u_adc_conversion_sequencer (.sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in), .conv_clock_div_sel_in(div), .converter_power_on_in(power),
        .input_source_sel_in(src), .external_channel_sel_in(chan),
        .reference_source_sel_in(refs), .result_format_sel_in(fmt), .start_in(start),
        .global_int_enable_in(gie), .conv_int_enable_in(cie), .stack_full_in(full),
        .int_request_clear_in(clr), .analog_power_out(pwr_o), .sample_phase_out(smp_o),
        .convert_phase_out(cnv_o), .conv_tick_out(tick_o), .conv_busy_flag_out(busy_o),
        .conv_done_out(done_o), .conv_int_request_out(req_o), .conv_int_service_out(svc_o),
        .external_channel_connect_out(ext_o), .channel_mux_sel_out(chan_o),
        .internal_signal_sel_out(int_o), .external_reference_pin_on_out(pin_o),
        .reference_mux_sel_out(ref_o), .result_format_out(fmt_o));
    analog_core_model u_analog_core_model (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
        .analog_power_in(pwr_o), .sample_phase_in(smp_o), .convert_phase_in(cnv_o),
        .conv_tick_in(tick_o), .busy_in(busy_o), .sample_cycles_out(n_smp),
        .convert_cycles_out(n_cnv), .busy_ticks_out(n_tck), .unpowered_out(unpw));
    task automatic print_verdict();
        if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask : cyc
    task automatic t_config();
        power = 1'b1;
        chan = 4'h6;
        for (int s = 0; s < 8; s++) begin
            src = s[2:0];
            cyc(1);
            check("ext connect", ext_o, (s == 0 || s == 4));
            check("internal sel", int_o, s[2:0]);
        end
        for (int r = 0; r < 16; r++) begin
            refs = r[3:0];
            cyc(1);
            check("ref pin on", pin_o, !(r == 0 || r >= 10));
            check("ref mux", ref_o, r[3:0]);
        end
        fmt = 1'b1;
        cyc(1);
        check("format", fmt_o, 1'b1);
        check("channel mux", chan_o, 4'h6);
        src = 3'h4;
        refs = 4'h1;
        cyc(1);
        check("paths on", {pwr_o, ext_o, pin_o}, 3'h7);
        power = 1'b0;
        cyc(1);
        check("power gate", {pwr_o, ext_o, pin_o}, 3'h0);
        power = 1'b1;
        cyc(20);
    endtask : t_config
    task automatic t_ticks();
        int n;
        for (int s = 0; s < 8; s++) begin
            div = s[2:0];
            cyc(2);
            for (n = 0; n < 300 && tick_o !== 1'b1; n++) cyc(1);
            if (n == 300) begin
                n_mismatch++;
                print_verdict();
            end
            n = 0;
            do begin
                cyc(1);
                n++;
            end while (tick_o !== 1'b1 && n < 300);
            if (tick_o !== 1'b1) begin
                n_mismatch++;
                print_verdict();
            end
            check("tick period", n[15:0], 16'h1 << s);
        end
    endtask : t_ticks
    task automatic t_convert(input logic [2:0] sel, input logic stk, input logic ints);
        int i;
        div = sel;
        gie = ints;
        cie = ints;
        full = stk;
        cyc(1);
        start = 1'b1;
        cyc(1);
        start = 1'b0;
        for (i = 0; i < 3000 && done_o !== 1'b1; i++) begin
            cyc(1);
            if (i == 2) check("busy set", busy_o, 1'b1);
        end
        if (i == 3000) begin
            n_mismatch++;
            print_verdict();
        end
        check("busy at done", busy_o, 1'b0);
        check("request", req_o, 1'b1);
        cyc(1);
        check("done width", done_o, 1'b0);
        check("service", svc_o, ints & !stk);
        check("ticks", n_tck, 8'h10);
        if (sel == 3'h0) check("phases", {n_smp, n_cnv}, 16'h040c);
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
        cyc(1);
        check("cleared", req_o, 1'b0);
    endtask : t_convert
    task automatic t_abort();
        logic seen_done;
        seen_done = 1'b0;
        div = 3'h3;
        start = 1'b1;
        cyc(1);
        start = 1'b0;
        cyc(60);
        check("abort phase", {busy_o, cnv_o}, 2'h3);
        power = 1'b0;
        cyc(1);
        check("abort busy", {busy_o, smp_o, cnv_o}, 3'h0);
        repeat (200) begin
            cyc(1);
            seen_done = seen_done | done_o;
        end
        check("abort done", {seen_done, req_o, unpw}, 3'h0);
        power = 1'b1;
        cyc(20);
    endtask : t_abort
    initial begin
        cyc(3);
        check("reset", {busy_o, req_o, pwr_o, done_o, svc_o}, 5'h00);
        resetn_in = 1'b1;
        t_config();
        t_ticks();
        t_convert(3'h0, 1'b0, 1'b1);
        t_convert(3'h0, 1'b1, 1'b1);
        t_convert(3'h4, 1'b0, 1'b0);
        t_convert(3'h1, 1'b0, 1'b1);
        t_abort();
        t_convert(3'h7, 1'b0, 1'b1);
        print_verdict();
    end
endmodule : tb
